// ---- hdl/lms_defines.svh ----
// Constants for the line monitor select control block.
// Function
// - Monitor select picks one channel 1-7 source
// - Channel 0 carries the monitored signal
// - Selected transmitter pair feeds channel 0 input
// - Selected receiver pair feeds channel 0 input
// - Monitored signal appears on channel 0 data outputs
// - Lower select bits zero disables monitoring
// - Host remote loopback forwards monitor to channel 0
// - Driver enable low puts drivers high impedance
// - Other logic keeps running while drivers off
// - Edge select sets serial clock edge, and recovered clock edge when data recovery is off
// - In data recovery, edge select sets receive data active level
// - Serial output launches falling if high, rising if low
`ifndef LMS_DEFINES_SVH
`define LMS_DEFINES_SVH
`define LMS_CHANNELS 8
`define LMS_CODES 16
`define LMS_SER_BITS 8
`define LMS_CTRL_OFS 8'h00
`define LMS_MONSEL_OFS 8'h04
`define LMS_SDATA_OFS 8'h08
`define LMS_STATUS_OFS 8'h0C
`define LMS_LUT_BASE 8'h40
`define LMS_LUT_LAST 8'h7C
`define LMS_CTRL_HOST_BIT 0
`define LMS_CTRL_DATAREC_BIT 1
`define LMS_CTRL_RLOOP0_BIT 2
`define LMS_SDATA_BUSY_BIT 8
`define LMS_ST_ACTIVE_BIT 4
`define LMS_ST_ISTX_BIT 5
`define LMS_ST_CHAN_LSB 6
`define LMS_ST_HIZ_BIT 9
`define LMS_ST_EDGE_BIT 10
`define LMS_ST_TOPADR_BIT 11
`define LMS_CTRL_RESET 3'h0
`define LMS_MONSEL_RESET 4'h0
`define LMS_SDATA_RESET 8'h00
`endif

// ---- hdl/lms_pkg.sv ----
// Types shared by the line monitor select control block.
package lms_pkg;
  typedef struct packed {
    logic valid;
    logic isTx;
    logic [2:0] chan;
  } lms_route_s;
  typedef struct packed {
    logic tip;
    logic ring;
  } lms_pair_s;
  typedef enum logic {LMS_SER_IDLE, LMS_SER_SHIFT} lms_ser_e;
endpackage : lms_pkg

// ---- hdl/lms_sync.sv ----
// Two-flop synchroniser bank for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module lms_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end
    else if (ce)
    begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end
  assign syncOut = stage2_reg;
endmodule : lms_sync
`default_nettype wire

// ---- hdl/lms_route_lut.sv ----
// Lookup from monitor select code to monitored channel and direction.
`timescale 1ns/1ps
`default_nettype none
`include "lms_defines.svh"
module lms_route_lut (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic wrEn,
  input wire logic [3:0] wrIdx,
  input wire lms_pkg::lms_route_s wrData,
  input wire logic [3:0] busIdx,
  output lms_pkg::lms_route_s busData,
  input wire logic [3:0] selIdx,
  output lms_pkg::lms_route_s selData
);
  import lms_pkg::*;
  lms_route_s table_reg [`LMS_CODES];
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < `LMS_CODES; i++)
      begin
        // Default map: low bits give the channel, top bit picks transmitter.
        table_reg[i].valid <= (i[2:0] != 3'h0);
        table_reg[i].isTx <= i[3];
        table_reg[i].chan <= i[2:0];
      end
    end
    else if (ce && wrEn)
    begin
      table_reg[wrIdx] <= wrData;
    end
  end
  assign busData = table_reg[busIdx];
  assign selData = table_reg[selIdx];
endmodule : lms_route_lut
`default_nettype wire

// ---- hdl/lms_line_monitor.sv ----
// Top level of the line monitor select control block.
`timescale 1ns/1ps
`default_nettype none
`include "lms_defines.svh"
module lms_line_monitor (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  input wire logic [3:0] monitorSelect,
  input wire logic topAddressInput,
  input wire logic driverEnable,
  input wire logic edgePolaritySelect,
  input wire logic serialClock,
  input wire logic [7:0] receiveLineTip,
  input wire logic [7:0] receiveLineRing,
  input wire logic [7:0] txDataPositive,
  input wire logic [7:0] txDataNegative,
  output logic [7:0] transmitLineTip,
  output logic [7:0] transmitLineTipOe,
  output logic [7:0] transmitLineRing,
  output logic [7:0] transmitLineRingOe,
  output logic [7:0] receiveDataPositive,
  output logic [7:0] receiveDataNegative,
  output logic [7:0] recoveredClock,
  output logic serialHostOutput,
  output logic serialHostOutputOe
);
  import lms_pkg::*;

  // Address compare, used by every register decode except the lookup table range.
  function automatic logic lmsHit(input logic [7:0] adr, input logic [7:0] ofs);
    lmsHit = (adr[7:2] == ofs[7:2]);
  endfunction : lmsHit

  // Byte lane merge of a write into an existing register value.
  function automatic logic [31:0] lmsMerge(input logic [31:0] oldVal, input logic [31:0] newVal,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[8*b +: 8] = newVal[8*b +: 8];
      end
    end
    lmsMerge = res;
  endfunction : lmsMerge

  // Pin inputs pass a two-flop synchroniser.
  logic [23:0] pinRaw;
  logic [23:0] pinSync;
  assign pinRaw = {topAddressInput, serialClock, edgePolaritySelect, driverEnable, monitorSelect,
                   receiveLineRing, receiveLineTip};
  lms_sync #(.WIDTH(24)) uSync (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .asyncIn(pinRaw),
    .syncOut(pinSync)
  );
  logic [7:0] rxTipSync;
  logic [7:0] rxRingSync;
  logic [3:0] pinMonSel;
  logic drvEnSync;
  logic edgeSync;
  logic sclkSync;
  logic topAdrSync;
  assign rxTipSync = pinSync[7:0];
  assign rxRingSync = pinSync[15:8];
  assign pinMonSel = pinSync[19:16];
  assign drvEnSync = pinSync[20];
  assign edgeSync = pinSync[21];
  assign sclkSync = pinSync[22];
  assign topAdrSync = pinSync[23];

  // Software registers.
  logic [2:0] ctrl_reg;
  logic [2:0] ctrl_next;
  logic [3:0] monSel_reg;
  logic [3:0] monSel_next;
  logic [7:0] serData_reg;
  logic [7:0] serData_next;
  logic ack_reg;
  logic [31:0] rdData_reg;
  logic [31:0] rdData_next;

  logic hostMode;
  logic dataRecovery;
  logic remoteLoop0;
  assign hostMode = ctrl_reg[`LMS_CTRL_HOST_BIT];
  assign dataRecovery = ctrl_reg[`LMS_CTRL_DATAREC_BIT];
  assign remoteLoop0 = ctrl_reg[`LMS_CTRL_RLOOP0_BIT];

  // Bus decode.
  logic busReq;
  logic busWr;
  logic hitCtrl;
  logic hitMonSel;
  logic hitSerData;
  logic hitStatus;
  logic hitLut;
  assign busReq = wbCyc && wbStb && !ack_reg;
  assign busWr = busReq && wbWe;
  assign hitCtrl = lmsHit(wbAdr, `LMS_CTRL_OFS);
  assign hitMonSel = lmsHit(wbAdr, `LMS_MONSEL_OFS);
  assign hitSerData = lmsHit(wbAdr, `LMS_SDATA_OFS);
  assign hitStatus = lmsHit(wbAdr, `LMS_STATUS_OFS);
  assign hitLut = (wbAdr >= `LMS_LUT_BASE) && (wbAdr <= `LMS_LUT_LAST);

  logic [31:0] wrMerged;
  assign wrMerged = lmsMerge(rdData_next, wbDatW, wbSel);

  // Monitor code selection and route lookup.
  logic [3:0] activeCode;
  lms_route_s route;
  lms_route_s lutBusData;
  lms_route_s lutWrData;
  logic lutWrEn;
  logic monitorActive;
  assign activeCode = hostMode ? monSel_reg : pinMonSel;
  assign lutWrEn = busWr && hitLut && wbSel[0];
  assign lutWrData = lms_route_s'(wbDatW[4:0]);
  lms_route_lut uLut (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .wrEn(lutWrEn),
    .wrIdx(wbAdr[5:2]),
    .wrData(lutWrData),
    .busIdx(wbAdr[5:2]),
    .busData(lutBusData),
    .selIdx(activeCode),
    .selData(route)
  );
  // A valid entry naming channel 0 would loop channel 0 onto itself, so it is refused.
  assign monitorActive = (activeCode[2:0] != 3'h0) && route.valid && (route.chan != 3'h0);

  // Transmit drivers and the signal that each channel places on its line.
  logic [7:0] txTip_reg;
  logic [7:0] txRing_reg;
  logic [7:0] txTip_next;
  logic [7:0] txRing_next;
  lms_pair_s txOnLine [`LMS_CHANNELS];
  lms_pair_s rxPin [`LMS_CHANNELS];
  lms_pair_s rxIn [`LMS_CHANNELS];
  lms_pair_s monSource;
  logic drvOe;
  assign drvOe = drvEnSync;

  // Monitored source for channel 0.
  assign monSource = route.isTx ? txOnLine[route.chan] : rxPin[route.chan];

  // Receive data polarity and recovered clock edge control.
  logic dataInvert;
  logic clockInvert;
  assign dataInvert = dataRecovery && !edgeSync;
  assign clockInvert = !dataRecovery && !edgeSync;

  logic [7:0] rdp_reg;
  logic [7:0] rdn_reg;
  logic [7:0] rclk_reg;
  logic [7:0] rdp_next;
  logic [7:0] rdn_next;
  logic [7:0] rclk_next;

  genvar ch;
  generate
    for (ch = 0; ch < `LMS_CHANNELS; ch++)
    begin : gChan
      assign rxPin[ch].tip = rxTipSync[ch];
      assign rxPin[ch].ring = rxRingSync[ch];
      // Line value seen by the monitor is what the driver really puts out.
      assign txOnLine[ch].tip = txTip_reg[ch] && drvOe;
      assign txOnLine[ch].ring = txRing_reg[ch] && drvOe;
      if (ch == 0)
      begin : gMon
        assign rxIn[ch] = monitorActive ? monSource : rxPin[ch];
        assign txTip_next[ch] = (hostMode && remoteLoop0) ? rxIn[ch].tip : txDataPositive[ch];
        assign txRing_next[ch] = (hostMode && remoteLoop0) ? rxIn[ch].ring : txDataNegative[ch];
      end
      else
      begin : gNorm
        assign rxIn[ch] = rxPin[ch];
        assign txTip_next[ch] = txDataPositive[ch];
        assign txRing_next[ch] = txDataNegative[ch];
      end
      assign rdp_next[ch] = rxIn[ch].tip ^ dataInvert;
      assign rdn_next[ch] = rxIn[ch].ring ^ dataInvert;
      assign rclk_next[ch] = (rxIn[ch].tip || rxIn[ch].ring) ^ clockInvert;
    end
  endgenerate

  // Data path keeps running regardless of the driver enable.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      txTip_reg <= 8'h00;
      txRing_reg <= 8'h00;
      rdp_reg <= 8'h00;
      rdn_reg <= 8'h00;
      rclk_reg <= 8'h00;
    end
    else if (ce)
    begin
      txTip_reg <= txTip_next;
      txRing_reg <= txRing_next;
      rdp_reg <= rdp_next;
      rdn_reg <= rdn_next;
      rclk_reg <= rclk_next;
    end
  end

  assign transmitLineTip = txTip_reg;
  assign transmitLineRing = txRing_reg;
  assign transmitLineTipOe = {`LMS_CHANNELS{drvOe}};
  assign transmitLineRingOe = {`LMS_CHANNELS{drvOe}};
  assign receiveDataPositive = rdp_reg;
  assign receiveDataNegative = rdn_reg;
  assign recoveredClock = rclk_reg;

  // Serial host output shifter.
  lms_ser_e serState_reg;
  lms_ser_e serState_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [3:0] bitCnt_reg;
  logic [3:0] bitCnt_next;
  logic sclkPrev_reg;
  logic sdo_reg;
  logic sdo_next;
  logic sdoOe_reg;
  logic sdoOe_next;
  logic launchEdge;
  logic serStart;
  logic serBusy;
  assign launchEdge = edgeSync ? (sclkPrev_reg && !sclkSync) : (!sclkPrev_reg && sclkSync);
  assign serStart = busWr && hitSerData && wbSel[0];
  assign serBusy = (serState_reg == LMS_SER_SHIFT);

  always_comb
  begin
    serState_next = serState_reg;
    shift_next = shift_reg;
    bitCnt_next = bitCnt_reg;
    sdo_next = sdo_reg;
    sdoOe_next = sdoOe_reg;
    unique case (serState_reg)
      LMS_SER_IDLE:
      begin
        sdoOe_next = 1'b0;
        if (serStart)
        begin
          shift_next = wbDatW[7:0];
          bitCnt_next = 4'h0;
          serState_next = LMS_SER_SHIFT;
        end
      end
      LMS_SER_SHIFT:
      begin
        if (launchEdge)
        begin
          if (bitCnt_reg == 4'(`LMS_SER_BITS))
          begin
            sdoOe_next = 1'b0;
            serState_next = LMS_SER_IDLE;
          end
          else
          begin
            sdo_next = shift_reg[7];
            sdoOe_next = 1'b1;
            shift_next = {shift_reg[6:0], 1'b0};
            bitCnt_next = bitCnt_reg + 4'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      serState_reg <= LMS_SER_IDLE;
      shift_reg <= 8'h00;
      bitCnt_reg <= 4'h0;
      sclkPrev_reg <= 1'b0;
      sdo_reg <= 1'b0;
      sdoOe_reg <= 1'b0;
    end
    else if (ce)
    begin
      serState_reg <= serState_next;
      shift_reg <= shift_next;
      bitCnt_reg <= bitCnt_next;
      sclkPrev_reg <= sclkSync;
      sdo_reg <= sdo_next;
      sdoOe_reg <= sdoOe_next;
    end
  end
  assign serialHostOutput = sdo_reg;
  assign serialHostOutputOe = sdoOe_reg;

  // Status word shows the block's own routing and pin state.
  logic [31:0] statusWord;
  assign statusWord = {20'h00000, topAdrSync, edgeSync, !drvOe, route.chan, route.isTx, monitorActive,
                       activeCode};

  // Read mux.
  always_comb
  begin
    rdData_next = 32'h00000000;
    if (hitCtrl)
    begin
      rdData_next = {29'h00000000, ctrl_reg};
    end
    else if (hitMonSel)
    begin
      rdData_next = {28'h0000000, monSel_reg};
    end
    else if (hitSerData)
    begin
      rdData_next = {23'h000000, serBusy, serData_reg};
    end
    else if (hitStatus)
    begin
      rdData_next = statusWord;
    end
    else if (hitLut)
    begin
      rdData_next = {27'h0000000, lutBusData};
    end
  end

  // Register writes honour byte lanes; the serial data word is refused while shifting.
  assign ctrl_next = (busWr && hitCtrl) ? wrMerged[2:0] : ctrl_reg;
  assign monSel_next = (busWr && hitMonSel) ? wrMerged[3:0] : monSel_reg;
  assign serData_next = (serStart && !serBusy) ? wbDatW[7:0] : serData_reg;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      ctrl_reg <= `LMS_CTRL_RESET;
      monSel_reg <= `LMS_MONSEL_RESET;
      serData_reg <= `LMS_SDATA_RESET;
      ack_reg <= 1'b0;
      rdData_reg <= 32'h00000000;
    end
    else if (ce)
    begin
      ctrl_reg <= ctrl_next;
      monSel_reg <= monSel_next;
      serData_reg <= serData_next;
      ack_reg <= busReq;
      rdData_reg <= busReq ? rdData_next : rdData_reg;
    end
  end
  assign wbAck = ack_reg;
  assign wbDatR = rdData_reg;
endmodule : lms_line_monitor
`default_nettype wire

// ---- tb/lms_line_monitor_assertions.sv ----
// Concurrent checks on the ports of the line monitor select control block.
`timescale 1ns/1ps
`default_nettype none
module lms_line_monitor_checker (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic [31:0] wbDatR,
  input wire logic wbAck,
  input wire logic driverEnable,
  input wire logic serialClock,
  input wire logic [7:0] txDataPositive,
  input wire logic [7:0] txDataNegative,
  input wire logic [7:0] transmitLineTip,
  input wire logic [7:0] transmitLineTipOe,
  input wire logic [7:0] transmitLineRing,
  input wire logic [7:0] transmitLineRingOe,
  input wire logic serialHostOutput,
  input wire logic serialHostOutputOe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic take;
  assign take = wbCyc && wbStb && !wbAck;
  property p_ack_cause; $past(ce) |-> (wbAck == ($past(rstn) && $past(take))); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack not one cycle after request");
  property p_ack_pulse; wbAck |=> !wbAck; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_dat_hold; !take |=> $stable(wbDatR); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data changed without access");
  property p_oe_track;
    $past(rstn) && $past(rstn, 2) && $past(ce) && $past(ce, 2) |-> transmitLineTipOe == {8{$past(driverEnable, 2)}};
  endproperty
  a_oe_track: assert property (p_oe_track) else $error("driver enable not followed");
  property p_oe_equal;
    transmitLineRingOe == transmitLineTipOe && (transmitLineTipOe == 8'h00 || transmitLineTipOe == 8'hFF);
  endproperty
  a_oe_equal: assert property (p_oe_equal) else $error("driver enables differ");
  property p_tx_follow;
    $past(rstn) && $past(ce) |-> (transmitLineTip & 8'hFE) == ($past(txDataPositive) & 8'hFE)
      && (transmitLineRing & 8'hFE) == ($past(txDataNegative) & 8'hFE);
  endproperty
  a_tx_follow: assert property (p_tx_follow) else $error("transmit value not registered");
  property p_ser_oe_quiet; $stable(serialClock) [*6] |-> $stable(serialHostOutputOe); endproperty
  a_ser_oe_quiet: assert property (p_ser_oe_quiet) else $error("serial enable moved without clock edge");
  property p_ser_dat_quiet; $stable(serialClock) [*6] |-> $stable(serialHostOutput); endproperty
  a_ser_dat_quiet: assert property (p_ser_dat_quiet) else $error("serial data moved without clock edge");
endmodule : lms_line_monitor_checker
bind lms_line_monitor lms_line_monitor_checker chk_u (.mclk(mclk), .rstn(rstn), .ce(ce), .wbCyc(wbCyc),
  .wbStb(wbStb), .wbDatR(wbDatR), .wbAck(wbAck), .driverEnable(driverEnable), .serialClock(serialClock),
  .txDataPositive(txDataPositive), .txDataNegative(txDataNegative), .transmitLineTip(transmitLineTip),
  .transmitLineTipOe(transmitLineTipOe), .transmitLineRing(transmitLineRing),
  .transmitLineRingOe(transmitLineRingOe), .serialHostOutput(serialHostOutput),
  .serialHostOutputOe(serialHostOutputOe));
`default_nettype wire

// ---- tb/lms_far_side.sv ----
// Far-side model: line receive pins, board strapping and serial clock source.
`timescale 1ns/1ps
`default_nettype none
module lms_far_side (
  input wire logic mclk,
  input wire logic [7:0] rxTip,
  input wire logic [7:0] rxRing,
  input wire logic edgeSel,
  input wire logic sclkRun,
  input wire logic serialHostOutput,
  input wire logic serialHostOutputOe,
  output logic [7:0] receiveLineTip,
  output logic [7:0] receiveLineRing,
  output logic topAddressInput,
  output logic serialClock,
  output logic [7:0] sampled,
  output logic sclkDone
);
  logic [2:0] div;
  logic [4:0] toggles;
  assign topAddressInput = 1'b0;
  assign sclkDone = toggles == 5'd18;
  // The serial clock rests at its idle level between frames and samples on the edge opposite the launch edge.
  always @(posedge mclk)
  begin
    receiveLineTip <= rxTip;
    receiveLineRing <= rxRing;
    if (!sclkRun)
    begin
      serialClock <= edgeSel;
      div <= 3'h0;
      toggles <= 5'h00;
    end
    else if (toggles < 5'd18)
    begin
      div <= div + 3'h1;
      if (div == 3'h7)
      begin
        serialClock <= !serialClock;
        toggles <= toggles + 5'h01;
        if (!serialClock == edgeSel && serialHostOutputOe)
          sampled <= {sampled[6:0], serialHostOutput};
      end
    end
  end
endmodule : lms_far_side
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking testbench for the line monitor select control block.
`timescale 1ns/1ps
`default_nettype none
`include "lms_defines.svh"
module tb;
  import lms_pkg::*;
  logic mclk, rstn, wbCyc, wbStb, wbWe, wbAck, driverEnable, edgeSel, sclkRun, sclk, topAdr, serial_host_output, sdoOe, done;
  logic [3:0] monitorSelect, c, wbSel;
  logic [7:0] wbAdr, rxTip, rxRing, txP, txN, lTip, lRing, tTip, tTipOe, tRing, tRingOe, rdp, rdn, rclk, sampled, a;
  logic [31:0] wbDatW, wbDatR, rd;
  logic s, r;
  int mismatches, compares, n;
  lms_line_monitor dut_u (.mclk(mclk), .rstn(rstn), .ce(1'b1), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .monitorSelect(monitorSelect),
    .topAddressInput(topAdr), .driverEnable(driverEnable), .edgePolaritySelect(edgeSel), .serialClock(sclk),
    .receiveLineTip(lTip), .receiveLineRing(lRing), .txDataPositive(txP), .txDataNegative(txN),
    .transmitLineTip(tTip), .transmitLineTipOe(tTipOe), .transmitLineRing(tRing), .transmitLineRingOe(tRingOe),
    .receiveDataPositive(rdp), .receiveDataNegative(rdn), .recoveredClock(rclk), .serialHostOutput(serial_host_output),
    .serialHostOutputOe(sdoOe));
  lms_far_side far_u (.mclk(mclk), .rxTip(rxTip), .rxRing(rxRing), .edgeSel(edgeSel), .sclkRun(sclkRun),
    .serialHostOutput(serial_host_output), .serialHostOutputOe(sdoOe), .receiveLineTip(lTip), .receiveLineRing(lRing),
    .topAddressInput(topAdr), .serialClock(sclk), .sampled(sampled), .sclkDone(done));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic end_of_test();
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk8
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int k = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= 4'hF;
    wbAdr <= adr;
    wbDatW <= dat;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (wbAck !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      mismatches++;
      end_of_test();
    end
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge mclk);
  endtask : wb
  // Sets line patterns that tell the routed source apart from every pair of its direction and the other pair on its channel, then checks channel 0.
  task automatic mon(input logic [3:0] code, input logic [3:0] src, input logic drvOn);
    c = src;
    a = 8'h01 << c[2:0];
    monitorSelect <= code;
    rxTip <= c[3] ? (~a & 8'hFE) : a;
    txP <= c[3] ? a : (~a & 8'hFE);
    rxRing <= c[3] ? ~(~a & 8'hFE) : ~a;
    txN <= c[3] ? ~a : ~(~a & 8'hFE);
    repeat (8) @(posedge mclk);
    s = (code[2:0] == 3'h0 || c[2:0] == 3'h0) ? rxTip[0] : (c[3] ? txP[c[2:0]] & drvOn : rxTip[c[2:0]]);
    r = (code[2:0] == 3'h0 || c[2:0] == 3'h0) ? rxRing[0] : (c[3] ? txN[c[2:0]] & drvOn : rxRing[c[2:0]]);
    chk8("rdp", {rxTip[7:1], s}, rdp);
    chk8("rdn", {rxRing[7:1], r}, rdn);
    wb(1'b0, `LMS_STATUS_OFS, 32'h0);
    chk("status", {20'h0, 1'b0, edgeSel, !drvOn, c[2:0], c[3], |code[2:0] && |c[2:0], code}, rd);
  endtask : mon
  initial
  begin
    rstn = 1'b0; wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0; wbAdr = 8'h00; wbDatW = 32'h0; driverEnable = 1'b1;
    edgeSel = 1'b1; sclkRun = 1'b0; monitorSelect = 4'h0; rxTip = 8'h00; rxRing = 8'h00; txP = 8'h00; txN = 8'h00;
    mismatches = 0;
    compares = 0;
    wbSel = 4'h0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    wb(1'b0, `LMS_CTRL_OFS, 32'h0);
    chk("ctrl", {29'h0, `LMS_CTRL_RESET}, rd);
    wb(1'b0, `LMS_MONSEL_OFS, 32'h0);
    chk("monsel", {28'h0, `LMS_MONSEL_RESET}, rd);
    wb(1'b1, 8'h20, 32'hFFFFFFFF);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    for (int i = 0; i < 16; i++)
    begin
      c = 4'(i);
      wb(1'b0, `LMS_LUT_BASE + 8'(4 * i), 32'h0);
      chk("lut", {27'h0, |c[2:0], c}, rd);
    end
    for (int i = 0; i < 16; i++)
      mon(4'(i), 4'(i), 1'b1);
    wb(1'b1, `LMS_LUT_BASE + 8'h14, 32'h1D);
    wb(1'b0, `LMS_LUT_BASE + 8'h14, 32'h0);
    chk("lut5", 32'h1D, rd);
    mon(4'h5, 4'hD, 1'b1);
    wb(1'b1, `LMS_LUT_BASE + 8'h14, 32'h15);
    driverEnable <= 1'b0;
    mon(4'hA, 4'hA, 1'b0);
    mon(4'h3, 4'h3, 1'b0);
    chk("oe", 32'h0, {16'h0, tTipOe, tRingOe});
    chk("hiz", 32'h1, {31'h0, rd[9]});
    driverEnable <= 1'b1;
    monitorSelect <= 4'h0;
    rxTip <= 8'h96;
    rxRing <= 8'h3C;
    for (int e = 0; e < 2; e++)
      for (int d = 0; d < 2; d++)
      begin
        edgeSel <= e[0];
        wb(1'b1, `LMS_CTRL_OFS, {30'h0, d[0], 1'b0});
        repeat (8) @(posedge mclk);
        chk8("rdp", rxTip ^ {8{d[0] & !e[0]}}, rdp);
        chk8("rdn", rxRing ^ {8{d[0] & !e[0]}}, rdn);
        chk8("rclk", (rxTip | rxRing) ^ {8{!d[0] & !e[0]}}, rclk);
      end
    edgeSel <= 1'b1;
    wb(1'b1, `LMS_CTRL_OFS, 32'h5);
    wb(1'b1, `LMS_MONSEL_OFS, 32'h2);
    monitorSelect <= 4'h3;
    rxTip <= 8'h04;
    txP <= 8'h00;
    repeat (8) @(posedge mclk);
    chk8("rdp", 8'h05, rdp);
    chk("tip0", 32'h1, {31'h0, tTip[0]});
    for (int e = 0; e < 2; e++)
    begin
      edgeSel <= e[0];
      a = e[0] ? 8'hA5 : 8'h3C;
      repeat (8) @(posedge mclk);
      wb(1'b1, `LMS_SDATA_OFS, {24'h0, a});
      wb(1'b0, `LMS_SDATA_OFS, 32'h0);
      chk("busy", {23'h0, 1'b1, a}, rd);
      sclkRun <= 1'b1;
      n = 0;
      do
      begin
        @(posedge mclk);
        n++;
      end
      while (done !== 1'b1 && n < 400);
      if (n >= 400)
      begin
        mismatches++;
        end_of_test();
      end
      repeat (8) @(posedge mclk);
      chk8("serial", a, sampled);
      wb(1'b0, `LMS_SDATA_OFS, 32'h0);
      chk("idle", {24'h0, a}, rd);
      sclkRun <= 1'b0;
      @(posedge mclk);
    end
    end_of_test();
  end
endmodule : tb
`default_nettype wire
